// file: verilog/mpr_pkg.sv
// constants, types and state layout of the port, rotate, bank and timer execution unit
package mpr_pkg;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_OR_BUS = 8'h88;
  localparam logic [7:0] OP_OR_P1 = 8'h89;
  localparam logic [7:0] OP_OR_P2 = 8'h8a;
  // base of the 8c..8f family; the low two bits pick expander port 4..7
  localparam logic [7:0] OP_OR_EXP = 8'h8c;
  localparam logic [7:0] OP_OUT_BUS = 8'h02;
  localparam logic [7:0] OP_OUT_P1 = 8'h39;
  localparam logic [7:0] OP_OUT_P2 = 8'h3a;
  localparam logic [7:0] OP_RET = 8'h83;
  localparam logic [7:0] OP_STATUS_RESTORING_RETURN = 8'h93;
  localparam logic [7:0] OP_ROL = 8'he7;
  localparam logic [7:0] OP_ROLC = 8'hf7;
  localparam logic [7:0] OP_ROR = 8'h77;
  localparam logic [7:0] OP_RORC = 8'h67;
  localparam logic [7:0] OP_PBANK0 = 8'he5;
  localparam logic [7:0] OP_PBANK1 = 8'hf5;
  localparam logic [7:0] OP_RBANK0 = 8'hc5;
  localparam logic [7:0] OP_RBANK1 = 8'hd5;
  localparam logic [7:0] OP_THALT = 8'h65;
  localparam logic [7:0] OP_CNT_GO = 8'h45;
  localparam logic [7:0] OP_TMR_GO = 8'h55;
  localparam logic [7:0] OP_SWAP = 8'h47;
  // base of the 28..2f family; the low three bits pick the working register
  localparam logic [7:0] OP_XCH = 8'h28;
  // masks that strip the port and register fields off an opcode
  localparam logic [7:0] PORT_FIELD_MASK = 8'hfc;
  localparam logic [7:0] REG_FIELD_MASK = 8'hf8;

  // ----------------------------------------
  // timing and reset values
  // ----------------------------------------
  localparam int PRESCALE_DIV = 32;
  localparam logic [4:0] PRE_LAST = 5'(PRESCALE_DIV - 1);
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_QPORT = 8'hff;
  localparam logic [11:0] RST_PC = 12'h000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } mpr_state_e;

  // one stack entry: saved status high nibble over the return pc
  typedef struct packed {
    logic [3:0] psw_hi;
    logic [11:0] pc;
  } mpr_frame_s;

  typedef struct packed {
    mpr_state_e state;
    logic done;
    logic [7:0] acc;
    logic cy;
    logic ac;
    logic f0;
    logic bs;
    logic dbf;
    logic [11:0] pc;
    logic [2:0] sp;
    logic [15:0][7:0] regs;
    mpr_frame_s [7:0] stack;
    logic in_svc;
    logic [7:0] bus;
    logic bus_oe;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [3:0][3:0] expd;
    logic [7:0] tmr;
    logic [4:0] pre;
    logic t_run;
    logic c_run;
    logic pend;
    logic ovf;
    logic [2:0] t1_sync;
    logic t1_lvl;
  } mpr_core_s;

endpackage

// file: verilog/mpr_core.sv
// execution unit for port or/output, returns, rotates, bank select and timer control
module mpr_core #(
  parameter bit SUPPRESS_EARLY_EDGE = 1'b0
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_I,
  input wire logic [7:0] OPERAND_I,
  input wire logic ACC_LOAD_I,
  output logic OP_READY_O,
  output logic OP_DONE_O,
  input wire logic PUSH_I,
  input wire logic PUSH_INT_I,
  input wire logic [11:0] PUSH_PC_I,
  input wire logic [10:0] PUSH_ADDR_I,
  input wire logic BUS_XFER_I,
  input wire logic T1_I,
  output logic [7:0] ACC_O,
  output logic [3:0] PSW_HI_O,
  output logic [11:0] PC_O,
  output logic [2:0] SP_O,
  output logic DBF_O,
  output logic IN_SERVICE_O,
  output logic [7:0] BUS_O,
  output logic BUS_OE_O,
  output logic [7:0] P1_O,
  output logic [7:0] P2_O,
  output logic [15:0] EXP_O,
  output logic [7:0] TIMER_O,
  output logic TIMER_OVF_O
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // folds the port and register field families onto their base opcode
  function automatic logic [7:0] op_class(input logic [7:0] op);
    logic [7:0] r;
    r = op;
    if ((op & mpr_pkg::PORT_FIELD_MASK) == mpr_pkg::OP_OR_EXP) begin
      r = mpr_pkg::OP_OR_EXP;
    end
    if ((op & mpr_pkg::REG_FIELD_MASK) == mpr_pkg::OP_XCH) begin
      r = mpr_pkg::OP_XCH;
    end
    return r;
  endfunction

  // instructions that hold the unit for a second cycle
  function automatic logic two_cycle(input logic [7:0] op);
    logic r;
    r = 1'b0;
    case (op_class(op))
      mpr_pkg::OP_OR_BUS, mpr_pkg::OP_OR_P1, mpr_pkg::OP_OR_P2,
      mpr_pkg::OP_OR_EXP, mpr_pkg::OP_OUT_BUS, mpr_pkg::OP_OUT_P1,
      mpr_pkg::OP_OUT_P2, mpr_pkg::OP_RET, mpr_pkg::OP_STATUS_RESTORING_RETURN: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // working register index within the selected bank
  function automatic logic [3:0] reg_idx(input logic bs, input logic [2:0] r);
    return {bs, r};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  mpr_pkg::mpr_core_s q_ff;
  mpr_pkg::mpr_core_s nxt_q;
  logic fall;
  logic inc;
  logic [2:0] sp_dn;
  logic [7:0] rv;
  logic [8:0] tsum;
  mpr_pkg::mpr_frame_s fr;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    nxt_q.ovf = 1'b0;
    inc = 1'b0;
    sp_dn = q_ff.sp - 3'h1;
    fr = q_ff.stack[sp_dn];
    rv = q_ff.regs[reg_idx(q_ff.bs, OP_I[2:0])];
    tsum = 9'h000;

    // three-stage sampler on test input one; level moves once stages 2 and 3 agree
    nxt_q.t1_sync = {q_ff.t1_sync[1:0], T1_I};
    if (q_ff.t1_sync[1] == q_ff.t1_sync[2]) begin
      nxt_q.t1_lvl = q_ff.t1_sync[2];
    end
    fall = q_ff.t1_lvl & ~q_ff.t1_sync[1] & ~q_ff.t1_sync[2];

    // prescaled timer ticks once per 32 enabled cycles
    if (q_ff.t_run) begin
      if (q_ff.pre == mpr_pkg::PRE_LAST) begin
        nxt_q.pre = 5'h00;
        inc = 1'b1;
      end else begin
        nxt_q.pre = q_ff.pre + 5'h01;
      end
    end

    // event mode counts falling edges; a single edge seen while stopped is remembered
    if (q_ff.c_run && fall) begin
      inc = 1'b1;
    end
    if (!q_ff.c_run && fall) begin
      nxt_q.pend = 1'b1;
    end

    // using the port as a bus drops the latched byte and returns it to input
    if (BUS_XFER_I) begin
      nxt_q.bus = mpr_pkg::RST_BYTE;
      nxt_q.bus_oe = 1'b0;
    end

    // accumulator load from the rest of the core; an opcode writing it wins
    if (ACC_LOAD_I) begin
      nxt_q.acc = OPERAND_I;
    end

    case (q_ff.state)
      mpr_pkg::ST_IDLE: begin
        if (PUSH_I) begin
          // call or interrupt entry: save pc with status nibble, bank select included
          nxt_q.stack[q_ff.sp] = {q_ff.cy, q_ff.ac, q_ff.f0, q_ff.bs, q_ff.pc};
          nxt_q.sp = q_ff.sp + 3'h1;
          if (PUSH_INT_I) begin
            nxt_q.in_svc = 1'b1;
            nxt_q.pc = {1'b0, PUSH_ADDR_I};
          end else begin
            nxt_q.pc = {q_ff.dbf, PUSH_ADDR_I};
          end
          nxt_q.done = 1'b1;
        end else if (OP_VALID_I) begin
          case (op_class(OP_I))
            mpr_pkg::OP_OR_BUS: begin
              nxt_q.bus = q_ff.bus | OPERAND_I;
              nxt_q.bus_oe = 1'b1;
            end
            mpr_pkg::OP_OR_P1: begin
              nxt_q.p1 = q_ff.p1 | OPERAND_I;
            end
            mpr_pkg::OP_OR_P2: begin
              nxt_q.p2 = q_ff.p2 | OPERAND_I;
            end
            mpr_pkg::OP_OR_EXP: begin
              nxt_q.expd[OP_I[1:0]] = q_ff.expd[OP_I[1:0]] | q_ff.acc[3:0];
            end
            mpr_pkg::OP_OUT_BUS: begin
              nxt_q.bus = q_ff.acc;
              nxt_q.bus_oe = 1'b1;
            end
            mpr_pkg::OP_OUT_P1: begin
              nxt_q.p1 = q_ff.acc;
            end
            mpr_pkg::OP_OUT_P2: begin
              nxt_q.p2 = q_ff.acc;
            end
            mpr_pkg::OP_RET: begin
              // pointer steps one entry; the entry carries both pc and status
              nxt_q.sp = sp_dn;
              nxt_q.pc = fr.pc;
            end
            mpr_pkg::OP_STATUS_RESTORING_RETURN: begin
              nxt_q.sp = sp_dn;
              nxt_q.pc = fr.pc;
              {nxt_q.cy, nxt_q.ac, nxt_q.f0, nxt_q.bs} = fr.psw_hi;
              nxt_q.in_svc = 1'b0;
            end
            mpr_pkg::OP_ROL: begin
              nxt_q.acc = {q_ff.acc[6:0], q_ff.acc[7]};
            end
            mpr_pkg::OP_ROLC: begin
              nxt_q.acc = {q_ff.acc[6:0], q_ff.cy};
              nxt_q.cy = q_ff.acc[7];
            end
            mpr_pkg::OP_ROR: begin
              nxt_q.acc = {q_ff.acc[0], q_ff.acc[7:1]};
            end
            mpr_pkg::OP_RORC: begin
              nxt_q.acc = {q_ff.cy, q_ff.acc[7:1]};
              nxt_q.cy = q_ff.acc[0];
            end
            mpr_pkg::OP_PBANK0: begin
              nxt_q.dbf = 1'b0;
            end
            mpr_pkg::OP_PBANK1: begin
              nxt_q.dbf = 1'b1;
            end
            mpr_pkg::OP_RBANK0: begin
              nxt_q.bs = 1'b0;
            end
            mpr_pkg::OP_RBANK1: begin
              nxt_q.bs = 1'b1;
            end
            mpr_pkg::OP_THALT: begin
              // halting wins over a tick landing in the same cycle
              nxt_q.t_run = 1'b0;
              nxt_q.c_run = 1'b0;
              inc = 1'b0;
            end
            mpr_pkg::OP_CNT_GO: begin
              nxt_q.t_run = 1'b0;
              nxt_q.c_run = 1'b1;
              nxt_q.pend = 1'b0;
              inc = (q_ff.pend | fall) & ~SUPPRESS_EARLY_EDGE;
            end
            mpr_pkg::OP_TMR_GO: begin
              nxt_q.t_run = 1'b1;
              nxt_q.c_run = 1'b0;
              nxt_q.pre = 5'h00;
              inc = 1'b0;
            end
            mpr_pkg::OP_SWAP: begin
              nxt_q.acc = {q_ff.acc[3:0], q_ff.acc[7:4]};
            end
            mpr_pkg::OP_XCH: begin
              nxt_q.acc = rv;
              nxt_q.regs[reg_idx(q_ff.bs, OP_I[2:0])] = q_ff.acc;
            end
            default: begin
              // opcodes outside this unit retire with no effect
            end
          endcase
          if (two_cycle(OP_I)) begin
            nxt_q.state = mpr_pkg::ST_WAIT;
          end else begin
            nxt_q.done = 1'b1;
          end
        end
      end
      mpr_pkg::ST_WAIT: begin
        // second machine cycle of a two-cycle instruction
        nxt_q.done = 1'b1;
        nxt_q.state = mpr_pkg::ST_IDLE;
      end
      default: begin
        nxt_q.state = mpr_pkg::ST_IDLE;
      end
    endcase

    // single shared incrementer for both count sources
    if (inc) begin
      tsum = {1'b0, q_ff.tmr} + 9'h001;
      nxt_q.tmr = tsum[7:0];
      nxt_q.ovf = tsum[8];
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // clock enable low freezes everything, samplers included
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q_ff <= '0;
      q_ff.state <= mpr_pkg::ST_IDLE;
      q_ff.pc <= mpr_pkg::RST_PC;
      q_ff.bus <= mpr_pkg::RST_BYTE;
      q_ff.bus_oe <= 1'b0;
      q_ff.p1 <= mpr_pkg::RST_QPORT;
      q_ff.p2 <= mpr_pkg::RST_QPORT;
      q_ff.t1_sync <= 3'h7;
      q_ff.t1_lvl <= 1'b1;
    end else if (CE_I) begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // push has priority over an opcode in the same cycle
  assign OP_READY_O = (q_ff.state == mpr_pkg::ST_IDLE) & ~PUSH_I & CE_I;
  assign OP_DONE_O = q_ff.done;
  assign ACC_O = q_ff.acc;
  assign PSW_HI_O = {q_ff.cy, q_ff.ac, q_ff.f0, q_ff.bs};
  assign PC_O = q_ff.pc;
  assign SP_O = q_ff.sp;
  assign DBF_O = q_ff.dbf;
  assign IN_SERVICE_O = q_ff.in_svc;
  assign BUS_O = q_ff.bus;
  assign BUS_OE_O = q_ff.bus_oe;
  assign P1_O = q_ff.p1;
  assign P2_O = q_ff.p2;
  assign EXP_O = q_ff.expd;
  assign TIMER_O = q_ff.tmr;
  assign TIMER_OVF_O = q_ff.ovf;

endmodule

// file: test/mpr_far_side.sv
// far-side model: event source on test input one and an external bus user
module mpr_far_side (
  input wire logic clk_i,
  output logic t1_o,
  output logic bus_xfer_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: input pulled high, no bus traffic
  initial begin
    t1_o = 1'b1;
    bus_xfer_o = 1'b0;
  end
  // each level held long enough for the three-flop sampler
  task automatic fall_edges(input int n);
    repeat (n) begin
      @(negedge clk_i);
      t1_o = 1'b0;
      repeat (4) @(negedge clk_i);
      t1_o = 1'b1;
      repeat (3) @(negedge clk_i);
    end
  endtask
  // one cycle of bus traffic, which wipes the output latch
  task automatic bus_cycle();
    @(negedge clk_i);
    bus_xfer_o = 1'b1;
    @(negedge clk_i);
    bus_xfer_o = 1'b0;
  endtask
endmodule

// file: test/mpr_core_props.sv
// concurrent checks on the ports of the execution unit
module mpr_core_props (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic OP_VALID_I,
  input wire logic [7:0] OP_I,
  input wire logic [7:0] OPERAND_I,
  input wire logic OP_READY_O,
  input wire logic OP_DONE_O,
  input wire logic BUS_XFER_I,
  input wire logic [7:0] ACC_O,
  input wire logic [3:0] PSW_HI_O,
  input wire logic [2:0] SP_O,
  input wire logic DBF_O,
  input wire logic IN_SERVICE_O,
  input wire logic [7:0] BUS_O,
  input wire logic BUS_OE_O,
  input wire logic [7:0] P1_O,
  input wire logic [7:0] TIMER_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // opcode accepted at this edge
  logic take;
  assign take = OP_VALID_I && OP_READY_O && CE_I;
  // --------------------------------
  // properties
  // --------------------------------
  // two-cycle ops block the port one extra cycle, then retire
  sequence s_two_step;
    !OP_READY_O ##1 OP_DONE_O;
  endsequence
  a_swap_halves: assert property (take && OP_I == mpr_pkg::OP_SWAP
    |=> ACC_O == {$past(ACC_O[3:0]), $past(ACC_O[7:4])}) else $error("swap wrong");
  a_bus_latch: assert property (take && OP_I == mpr_pkg::OP_OUT_BUS
    |=> (BUS_OE_O && BUS_O == $past(ACC_O)) ##0 s_two_step) else $error("bus out wrong");
  a_bus_or_imm: assert property (take && OP_I == mpr_pkg::OP_OR_BUS
    |=> BUS_O == ($past(BUS_O) | $past(OPERAND_I))) else $error("bus or wrong");
  a_bus_release: assert property (BUS_XFER_I && OP_READY_O && !OP_VALID_I
    |=> !BUS_OE_O && BUS_O == 8'h00) else $error("bus kept after transfer");
  a_port_or_imm: assert property (take && OP_I == mpr_pkg::OP_OR_P1
    |=> P1_O == ($past(P1_O) | $past(OPERAND_I))) else $error("port or wrong");
  a_port_out: assert property (take && OP_I == mpr_pkg::OP_OUT_P1
    |=> (P1_O == $past(ACC_O)) ##0 s_two_step) else $error("port out wrong");
  a_prog_bank: assert property (take && OP_I[3:0] == 4'h5 && OP_I[7:5] == 3'h7
    |=> DBF_O == $past(OP_I[4])) else $error("program bank wrong");
  a_reg_bank: assert property (take && OP_I[3:0] == 4'h5 && OP_I[7:5] == 3'h6
    |=> PSW_HI_O[0] == $past(OP_I[4])) else $error("register bank wrong");
  a_ret_plain: assert property (take && OP_I == mpr_pkg::OP_RET
    |=> SP_O == $past(SP_O) - 3'h1 && PSW_HI_O == $past(PSW_HI_O)) else $error("return wrong");
  a_ret_status: assert property (take && OP_I == mpr_pkg::OP_STATUS_RESTORING_RETURN
    |=> SP_O == $past(SP_O) - 3'h1 && !IN_SERVICE_O) else $error("status return wrong");
  a_timer_halt: assert property (take && OP_I == mpr_pkg::OP_THALT
    |=> ##1 $stable(TIMER_O) [*8]) else $error("timer runs after halt");
endmodule

bind mpr_core mpr_core_props i_props (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
  .OP_VALID_I(OP_VALID_I), .OP_I(OP_I), .OPERAND_I(OPERAND_I), .OP_READY_O(OP_READY_O),
  .OP_DONE_O(OP_DONE_O), .BUS_XFER_I(BUS_XFER_I), .ACC_O(ACC_O), .PSW_HI_O(PSW_HI_O),
  .SP_O(SP_O), .DBF_O(DBF_O), .IN_SERVICE_O(IN_SERVICE_O), .BUS_O(BUS_O),
  .BUS_OE_O(BUS_OE_O), .P1_O(P1_O), .TIMER_O(TIMER_O));

// file: test/mpr_core_tb_top.sv
// self-checking bench of the execution unit
module mpr_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, valid, push, push_int, t1, xfer, ready, done, dbf, insvc, oe;
  logic ce, acc_ld, ovf;
  logic [7:0] op, arg, acc, bus, p1, p2, tmr;
  logic [10:0] addr;
  logic [3:0] program_status_word;
  logic [11:0] pc;
  logic [2:0] sp;
  logic [15:0] expd;
  logic [7:0] rot_ops [11] = '{8'he7, 8'h77, 8'hf7, 8'hf7, 8'h67, 8'h67, 8'h47, 8'h2f, 8'h2f,
    8'h8c, 8'h8f};
  // {expander ports, status nibble, accumulator} after each step, starting from 96
  logic [27:0] rot_exp [11] = '{28'h000002d, 28'h0000096, 28'h000082c, 28'h0000059,
    28'h000082c, 28'h0000096, 28'h0000069, 28'h0000000, 28'h0000069, 28'h0009069,
    28'h9009069};
  logic [3:0] ovfs = 4'h0;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  mpr_core i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .OP_VALID_I(valid),
    .OP_I(op), .OPERAND_I(arg), .ACC_LOAD_I(acc_ld), .OP_READY_O(ready), .OP_DONE_O(done),
    .PUSH_I(push),
    .PUSH_INT_I(push_int), .PUSH_PC_I(12'h000), .PUSH_ADDR_I(addr), .BUS_XFER_I(xfer),
    .T1_I(t1), .ACC_O(acc), .PSW_HI_O(program_status_word), .PC_O(pc), .SP_O(sp), .DBF_O(dbf),
    .IN_SERVICE_O(insvc), .BUS_O(bus), .BUS_OE_O(oe), .P1_O(p1), .P2_O(p2), .EXP_O(expd),
    .TIMER_O(tmr), .TIMER_OVF_O(ovf));
  mpr_far_side i_far (.clk_i(clk), .t1_o(t1), .bus_xfer_o(xfer));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the roughly 2200 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  // overflow pulse stands one cycle, so it is counted mid-cycle
  always @(negedge clk) begin
    if (ovf === 1'b1) begin
      ovfs <= ovfs + 4'h1;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // offer one opcode, hold it until taken, then wait for retirement
  task automatic exec(input logic [7:0] o, input logic [7:0] b);
    int n;
    @(negedge clk);
    valid = 1'b1;
    op = o;
    arg = b;
    n = 0;
    while (ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk(done, 1'b1);
  endtask
  // call or interrupt entry, taken at the next edge since the unit is idle
  task automatic enter(input logic it, input logic [10:0] a);
    @(negedge clk);
    push = 1'b1;
    push_int = it;
    addr = a;
    @(negedge clk);
    push = 1'b0;
    chk(done, 1'b1);
  endtask
  // core-side accumulator load over one edge, no opcode offered
  task automatic load_acc(input logic [7:0] v);
    @(negedge clk);
    acc_ld = 1'b1;
    arg = v;
    @(negedge clk);
    acc_ld = 1'b0;
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence: ports, bus, accumulator ops, banks, returns, timer
  initial begin
    rst_n = 1'b0;
    valid = 1'b0;
    ce = 1'b1;
    acc_ld = 1'b0;
    push = 1'b0;
    push_int = 1'b0;
    op = 8'h00;
    arg = 8'h00;
    addr = 11'h000;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk({oe, p1, p2}, 17'h0ffff);
    exec(mpr_pkg::OP_OUT_P1, 8'h00);
    exec(mpr_pkg::OP_OR_P1, 8'h5a);
    exec(mpr_pkg::OP_OR_P2, 8'h24);
    chk({p1, p2}, 16'h5aff);
    exec(mpr_pkg::OP_OUT_P2, 8'h00);
    exec(mpr_pkg::OP_OR_P2, 8'h81);
    chk({p1, p2}, 16'h5a81);
    exec(mpr_pkg::OP_OUT_BUS, 8'h00);
    chk({oe, bus}, 9'h100);
    exec(mpr_pkg::OP_OR_BUS, 8'h3c);
    exec(mpr_pkg::OP_OR_BUS, 8'hc1);
    exec(mpr_pkg::OP_ROL, 8'h00);
    chk({oe, bus}, 9'h1fd);
    i_far.bus_cycle();
    chk({oe, bus}, 9'h000);
    load_acc(8'h96);
    foreach (rot_ops[k]) begin
      exec(rot_ops[k], 8'h00);
      chk({expd, program_status_word, acc}, rot_exp[k]);
    end
    exec(mpr_pkg::OP_PBANK1, 8'h00);
    enter(1'b0, 11'h123);
    chk({dbf, sp, pc}, {1'b1, 3'h1, 12'h923});
    exec(mpr_pkg::OP_PBANK0, 8'h00);
    enter(1'b0, 11'h456);
    chk({dbf, sp, pc}, {1'b0, 3'h2, 12'h456});
    exec(mpr_pkg::OP_RET, 8'h00);
    chk({sp, pc}, {3'h1, 12'h923});
    exec(mpr_pkg::OP_RET, 8'h00);
    chk({sp, pc}, 15'h0000);
    exec(mpr_pkg::OP_RBANK1, 8'h00);
    exec(8'h2f, 8'h00);
    chk(acc, 8'h00);
    enter(1'b1, 11'h7ff);
    chk({insvc, program_status_word, pc}, {1'b1, 4'h1, 12'h7ff});
    exec(mpr_pkg::OP_RBANK0, 8'h00);
    chk(program_status_word, 4'h0);
    exec(8'h2f, 8'h00);
    chk(acc, 8'h00);
    exec(mpr_pkg::OP_STATUS_RESTORING_RETURN, 8'h00);
    chk({insvc, program_status_word, sp, pc}, {1'b0, 4'h1, 3'h0, 12'h000});
    enter(1'b1, 11'h010);
    exec(mpr_pkg::OP_RBANK0, 8'h00);
    exec(mpr_pkg::OP_RET, 8'h00);
    chk({program_status_word, sp}, 7'h00);
    exec(mpr_pkg::OP_TMR_GO, 8'h00);
    repeat (20) @(negedge clk);
    chk(tmr, 8'h00);
    // enable low for 20 cycles: the prescaler must not move meanwhile
    ce = 1'b0;
    repeat (20) @(negedge clk);
    chk(tmr, 8'h00);
    ce = 1'b1;
    repeat (20) @(negedge clk);
    chk(tmr, 8'h01);
    exec(mpr_pkg::OP_THALT, 8'h00);
    i_far.fall_edges(1);
    chk(tmr, 8'h01);
    exec(mpr_pkg::OP_CNT_GO, 8'h00);
    repeat (2) @(negedge clk);
    chk(tmr, 8'h02);
    i_far.fall_edges(3);
    repeat (2) @(negedge clk);
    chk(tmr, 8'h05);
    i_far.fall_edges(250);
    chk({ovfs, tmr}, 12'h0ff);
    i_far.fall_edges(1);
    repeat (2) @(negedge clk);
    chk({ovfs, tmr}, 12'h100);
    exec(mpr_pkg::OP_THALT, 8'h00);
    end_of_test();
  end
endmodule
